// ==== src/ring_messenger_pkg.sv ====
/*
  shared constants for the peer status ring messenger: clock and link
  timing, frame layout, register map, field positions and the frame
  check function.
  assumes a 40 MHz pclk; the frame check runs combinationally in one cycle.
*/
package ring_messenger_pkg;

  // clock and link timing
  localparam int CLK_HZ        = 40_000_000;           // pclk rate
  localparam int RATE_HI_BPS   = 128_000;              // fast link rate
  localparam int RATE_LO_BPS   = 64_000;               // forced link rate
  localparam int BIT_CYC_HI    = CLK_HZ / RATE_HI_BPS; // pclk per fast bit
  localparam int BIT_CYC_LO    = CLK_HZ / RATE_LO_BPS; // pclk per slow bit
  localparam int BIT_CNT_W     = 10;                   // bit timer width
  localparam int INTEGRITY_MS  = 1000;                 // longest resend gap
  localparam int INTEGRITY_CYC = (CLK_HZ / 1000) * INTEGRITY_MS;
  localparam int OFFLINE_MS    = 2000;                 // peer silence window
  localparam int OFFLINE_CYC   = (CLK_HZ / 1000) * OFFLINE_MS;

  // frame layout: start bit, body then check word lsb first, stop bit
  localparam int NODE_W   = 4;                         // sender number
  localparam int NODES    = 16;                        // peer numbers
  localparam int STAT_W   = 16;                        // packed status bits
  localparam int CRC_W    = 32;                        // check word
  localparam int BODY_W   = NODE_W + STAT_W;           // {node, status}
  localparam int FRAME_W  = BODY_W + CRC_W;            // {crc, body}
  localparam int FCNT_W   = 6;                         // bit count width
  localparam logic [CRC_W-1:0] CRC_POLY = 32'h04C1_1DB7;
  localparam logic [CRC_W-1:0] CRC_INIT = 32'hFFFF_FFFF;

  // register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS      = 8'h00;
  localparam logic [ADDR_W-1:0] NODE_OFS      = 8'h04;
  localparam logic [ADDR_W-1:0] TX_STAT_OFS   = 8'h08;
  localparam logic [ADDR_W-1:0] RX_STAT_OFS   = 8'h0C;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS  = 8'h10;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS  = 8'h14;
  localparam logic [ADDR_W-1:0] OFFLINE_OFS   = 8'h18;
  localparam logic [ADDR_W-1:0] LINK_INFO_OFS = 8'h1C;

  // control fields
  localparam int CTRL_W          = 4;
  localparam int CTRL_EN_BIT     = 0;  // messenger enable
  localparam int CTRL_RING_BIT   = 1;  // ring topology expected
  localparam int CTRL_BRIDGE_BIT = 2;  // channel_bridging_select
  localparam int CTRL_FAST_BIT   = 3;  // ask for the fast rate
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
  localparam logic [NODE_W-1:0] NODE_RESET = 4'h1;

  // interrupt status / mask fields
  localparam int IRQ_W           = 4;
  localparam int IRQ_RING_BIT    = 0;  // ring break raised
  localparam int IRQ_CRC_BIT     = 1;  // corrupted frame seen
  localparam int IRQ_OFFLINE_BIT = 2;  // a peer went offline
  localparam int IRQ_RX_BIT      = 3;  // peer status accepted

  // link info fields (read only)
  localparam int INFO_DUAL_BIT  = 0;
  localparam int INFO_FIBRE_BIT = 1;
  localparam int INFO_FIXED_BIT = 2;
  localparam int INFO_FAST_BIT  = 3;
  localparam int INFO_BREAK_BIT = 4;
  localparam int INFO_OUTST_BIT = 5;
  localparam int RX_NODE_POS    = 16;  // sender field in rx status

  // serial crc over the body, msb first
  function automatic logic [CRC_W-1:0] crc_of(input logic [BODY_W-1:0] d);
    logic [CRC_W-1:0] c;
    logic             fb;
    c = CRC_INIT;
    for (int i = BODY_W - 1; i >= 0; i--) begin
      fb = c[CRC_W-1] ^ d[i];
      c  = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
    end
    return c;
  endfunction

endpackage

// ==== src/link_channel.sv ====
/*
  one serial channel: a frame transmitter and a frame receiver.
  assumes rx_line is synchronous to pclk and idles high; bit_cyc only
  changes while both directions are idle.
*/
module link_channel
  import ring_messenger_pkg::*;
#(
  parameter int FW = FRAME_W                   // frame width in bits
) (
  input  wire logic                 pclk,      // system clock
  input  wire logic                 presetn,   // async reset, active low
  input  wire logic                 ce,        // clock enable
  input  wire logic [BIT_CNT_W-1:0] bit_cyc,   // pclk cycles per bit
  input  wire logic                 tx_start,  // launch tx_frame
  input  wire logic [FW-1:0]        tx_frame,  // frame to send
  output logic                      tx_busy,   // transmitter occupied
  output logic                      tx_line,   // serial out, idles high
  input  wire logic                 rx_line,   // serial in
  output logic                      rx_valid,  // one-cycle frame pulse
  output logic [FW-1:0]             rx_frame   // last received frame
);

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_type;

  logic [FW:0]          tx_sh_q;    // start bit plus frame
  logic [FCNT_W-1:0]    tx_bits_q;  // bits still to send
  logic [BIT_CNT_W-1:0] tx_cnt_q;   // bit period timer
  rx_state_type         rx_st_q;    // receiver state
  logic [BIT_CNT_W-1:0] rx_cnt_q;   // sample timer
  logic [FCNT_W-1:0]    rx_bits_q;  // data bits left
  logic [FW-1:0]        rx_sh_q;    // assembling frame

  // transmitter: stop bit falls out of the ones shifted in
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_busy   <= 1'b0;
      tx_line   <= 1'b1;
      tx_sh_q   <= '0;
      tx_bits_q <= '0;
      tx_cnt_q  <= '0;
    end else if (ce) begin
      if (!tx_busy) begin
        if (tx_start) begin           // start bit goes out one cycle after busy rises
          tx_busy   <= 1'b1;
          tx_sh_q   <= {tx_frame, 1'b0};
          tx_bits_q <= FCNT_W'(FW + 2);
          tx_cnt_q  <= '0;
        end
      end else if (tx_cnt_q != '0) begin
        tx_cnt_q <= tx_cnt_q - 1'b1;
      end else if (tx_bits_q != '0) begin
        tx_line   <= tx_sh_q[0];
        tx_sh_q   <= {1'b1, tx_sh_q[FW:1]};
        tx_bits_q <= tx_bits_q - 1'b1;
        tx_cnt_q  <= bit_cyc - 1'b1;
      end else begin
        tx_busy <= 1'b0;              // stop bit fully sent
      end
    end
  end

  // receiver: samples at mid bit, bad stop bit drops the frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q   <= RX_IDLE;
      rx_cnt_q  <= '0;
      rx_bits_q <= '0;
      rx_sh_q   <= '0;
      rx_valid  <= 1'b0;
      rx_frame  <= '0;
    end else if (ce) begin
      rx_valid <= 1'b0;
      if (rx_st_q != RX_IDLE && rx_cnt_q != '0) begin
        rx_cnt_q <= rx_cnt_q - 1'b1;
      end else begin
        case (rx_st_q)
          RX_IDLE: if (!rx_line) begin
            rx_st_q  <= RX_START;
            rx_cnt_q <= bit_cyc >> 1;
          end
          RX_START: begin              // glitch filter on start bit
            rx_st_q   <= rx_line ? RX_IDLE : RX_DATA;
            rx_cnt_q  <= bit_cyc - 1'b1;
            rx_bits_q <= FCNT_W'(FW);
          end
          RX_DATA: begin
            rx_sh_q   <= {rx_line, rx_sh_q[FW-1:1]};
            rx_bits_q <= rx_bits_q - 1'b1;
            rx_cnt_q  <= bit_cyc - 1'b1;
            if (rx_bits_q == FCNT_W'(1)) rx_st_q <= RX_STOP;
          end
          RX_STOP: begin
            rx_st_q <= RX_IDLE;
            if (rx_line) begin
              rx_valid <= 1'b1;
              rx_frame <= rx_sh_q;
            end
          end
          default: rx_st_q <= RX_IDLE;
        endcase
      end
    end
  end

endmodule

// ==== src/peer_status_ring_messenger.sv ====
/*
  peer status ring messenger: originates, checks and forwards packed
  status frames on one or two serial channels, with an apb register file.
  assumes peers use the same frame layout and bit rate, and that the
  card straps are stable from reset onward.
*/
// Chosen here: the register offsets and the APB slave port.
// Notes on behaviour
// - dual card sends own frames on both channels
// - single card sends on channel one only
// - foreign sender frames are forwarded onward
// - unchanged state resent at most 1000 ms apart
// - status change sends at once unless busy
// - ring mode: missing own return flags break
// - offline flag per silent peer, sixteen peers
// - own node number in every originated frame
// - fast rate only on fibre cards, else slow
// - both channels share one bit rate
// - fixed-rate cards ignore the rate selection
// - bridging passes channel one frames to two
// - hop time about 0.4 or 0.8 ms
// - every received frame checked by 32-bit crc
module peer_status_ring_messenger
  import ring_messenger_pkg::*;
#(
  parameter int INTEGRITY_CYCLES = INTEGRITY_CYC, // resend gap in pclk
  parameter int OFFLINE_CYCLES   = OFFLINE_CYC    // peer silence window
) (
  input  wire logic              pclk,            // system clock
  input  wire logic              presetn,         // async reset, active low
  input  wire logic              ce,              // clock enable
  input  wire logic [ADDR_W-1:0] paddr,           // apb address
  input  wire logic              psel,            // apb select
  input  wire logic              penable,         // apb access phase
  input  wire logic              pwrite,          // apb write
  input  wire logic [31:0]       pwdata,          // apb write data
  output logic      [31:0]       prdata,          // apb read data
  output logic                   pready,          // apb ready
  output logic                   pslverr,         // apb error
  input  wire logic              dual_channel_card, // strap: two channels
  input  wire logic              fibre_card,      // strap: fast capable
  input  wire logic              fixed_rate_card, // strap: slow only
  input  wire logic              rx_line_1,       // channel one serial in
  input  wire logic              rx_line_2,       // channel two serial in
  output logic                   tx_line_1,       // channel one serial out
  output logic                   tx_line_2,       // channel two serial out
  output logic                   ring_break,      // ring return missing
  output logic                   irq              // level interrupt
);

  localparam int IW = $clog2(INTEGRITY_CYCLES + 1);
  localparam int OW = $clog2(OFFLINE_CYCLES + 1);

  // configuration and software state
  logic [CTRL_W-1:0]  ctrl_q;            // control register
  logic [NODE_W-1:0]  local_node_number; // own sender number
  logic [STAT_W-1:0]  tx_stat_q;         // outgoing status bits
  logic [STAT_W-1:0]  sent_stat_q;       // status last originated
  logic [STAT_W-1:0]  rx_stat_q;         // last accepted peer status
  logic [NODE_W-1:0]  rx_node_q;         // its sender
  logic [IRQ_W-1:0]   irq_stat_q;        // sticky events
  logic [IRQ_W-1:0]   irq_mask_q;        // event enables
  logic [NODES-1:0]   offline_q;         // per-peer offline flags
  logic [NODES-1:0]   seen_q;            // heard within the window
  logic               outstanding_q;     // own frame not yet back
  logic               straps_q;          // straps captured
  logic               dual_q;            // captured straps
  logic               fibre_q;
  logic               fixed_q;
  logic [IW-1:0]      integ_cnt_q;       // cycles to next integrity send
  logic [OW-1:0]      win_cnt_q;         // offline window timer

  // per-channel scheduling
  logic [1:0]               loc_pend_q;  // own frame waiting
  logic [1:0]               fwd_pend_q;  // forwarded frame waiting
  logic [FRAME_W-1:0]       fwd_frame_q [2];
  logic [1:0]               ch_on;       // channel fitted
  logic [1:0]               tx_busy;
  logic [1:0]               tx_start;
  logic [1:0]               rx_valid;
  logic [FRAME_W-1:0]       rx_frame [2];
  logic [FRAME_W-1:0]       tx_frame [2];
  logic [1:0]               rx_good;     // crc passes
  logic [1:0]               rx_own;      // good and from us
  logic [1:0]               rx_peer;     // good and from a peer
  logic [FRAME_W-1:0]       own_frame;   // frame built from current state

  // apb and derived terms
  logic               wr_en;             // write takes effect
  logic               en;
  logic               fast_act;          // fast rate in force
  logic [BIT_CNT_W-1:0] bit_cyc;         // shared bit period
  logic               want_send;         // change or integrity due
  logic               launch;            // own frame leaves channel one
  logic               win_end;           // offline window closes
  logic               break_ev;
  logic [NODES-1:0]   seen_now;          // peers heard this cycle
  logic [NODES-1:0]   new_offline;
  logic [IRQ_W-1:0]   irq_ev;

  assign wr_en    = psel & penable & pready & pwrite;
  assign en       = ctrl_q[CTRL_EN_BIT];
  // slow unless fibre card asks for fast; fixed cards ignore the ask
  assign fast_act = fibre_q & ~fixed_q & ctrl_q[CTRL_FAST_BIT];
  // one period feeds both channels, so they cannot differ
  assign bit_cyc  = fast_act ? BIT_CNT_W'(BIT_CYC_HI)
                             : BIT_CNT_W'(BIT_CYC_LO);
  assign ch_on    = {dual_q, 1'b1};
  assign own_frame = {crc_of({local_node_number, tx_stat_q}),
                      local_node_number, tx_stat_q};

  // frame classification per channel
  always_comb begin
    seen_now = '0;
    for (int c = 0; c < 2; c++) begin
      rx_good[c] = rx_valid[c] &&
        crc_of(rx_frame[c][BODY_W-1:0]) == rx_frame[c][FRAME_W-1:BODY_W];
      rx_own[c]  = rx_good[c] &&
        rx_frame[c][BODY_W-1:STAT_W] == local_node_number;
      rx_peer[c] = rx_good[c] && !rx_own[c];
      if (rx_peer[c] && en) seen_now[rx_frame[c][BODY_W-1:STAT_W]] = 1'b1;
    end
  end

  // channel start: own frame has priority over forwarding
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      tx_start[c] = ch_on[c] & ~tx_busy[c] & (loc_pend_q[c] | fwd_pend_q[c]);
      tx_frame[c] = loc_pend_q[c] ? own_frame : fwd_frame_q[c];
    end
  end

  assign want_send = en && loc_pend_q == 2'b00 &&
                     (tx_stat_q != sent_stat_q || integ_cnt_q == '0);
  assign launch    = tx_start[0] & loc_pend_q[0];
  assign win_end   = en && win_cnt_q == '0;
  assign break_ev  = launch & outstanding_q & ctrl_q[CTRL_RING_BIT]
                     & ~(rx_own[0] | rx_own[1]);
  assign new_offline = win_end ? (~seen_q & ~seen_now & ~offline_q) : '0;
  assign irq_ev[IRQ_RING_BIT]    = break_ev;
  assign irq_ev[IRQ_CRC_BIT]     = |(rx_valid & ~rx_good);
  assign irq_ev[IRQ_OFFLINE_BIT] = |new_offline;
  assign irq_ev[IRQ_RX_BIT]      = en & |rx_peer;

  // strap capture after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      straps_q <= 1'b0;
      dual_q   <= 1'b0;
      fibre_q  <= 1'b0;
      fixed_q  <= 1'b0;
    end else if (ce && !straps_q) begin
      straps_q <= 1'b1;
      dual_q   <= dual_channel_card;
      fibre_q  <= fibre_card;
      fixed_q  <= fixed_rate_card;
    end
  end

  // apb slave: one wait state, so every access takes three cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (ce) begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        prdata <= '0;
        case (paddr)
          CTRL_OFS:      prdata <= 32'(ctrl_q);
          NODE_OFS:      prdata <= 32'(local_node_number);
          TX_STAT_OFS:   prdata <= 32'(tx_stat_q);
          RX_STAT_OFS:   prdata <= (32'(rx_node_q) << RX_NODE_POS)
                                   | 32'(rx_stat_q);
          IRQ_STAT_OFS:  prdata <= 32'(irq_stat_q);
          IRQ_MASK_OFS:  prdata <= 32'(irq_mask_q);
          OFFLINE_OFS:   prdata <= 32'(offline_q);
          LINK_INFO_OFS: prdata <= 32'({outstanding_q, ring_break, fast_act,
                                        fixed_q, fibre_q, dual_q});
          default:       pslverr <= 1'b1;   // unmapped answers an error
        endcase
        if (pwrite) prdata <= '0;
      end
    end
  end

  // writable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q            <= CTRL_RESET;
      local_node_number <= NODE_RESET;
      tx_stat_q         <= '0;
      irq_mask_q        <= '0;
    end else if (ce && wr_en) begin
      case (paddr)
        CTRL_OFS:     ctrl_q            <= pwdata[CTRL_W-1:0];
        NODE_OFS:     local_node_number <= pwdata[NODE_W-1:0];
        TX_STAT_OFS:  tx_stat_q         <= pwdata[STAT_W-1:0];
        IRQ_MASK_OFS: irq_mask_q        <= pwdata[IRQ_W-1:0];
        default:      ;                 // read-only, write-one-clear or unmapped
      endcase
    end
  end

  // sticky status: a new event wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
      irq        <= 1'b0;
    end else if (ce) begin
      irq_stat_q <= (irq_stat_q &
                     ~((wr_en && paddr == IRQ_STAT_OFS) ?
                       pwdata[IRQ_W-1:0] : '0)) | irq_ev;
      irq        <= |(irq_stat_q & irq_mask_q);
    end
  end

  // origination: pending flags per channel, integrity timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loc_pend_q  <= '0;
      sent_stat_q <= '0;
      integ_cnt_q <= '0;
    end else if (ce) begin
      for (int c = 0; c < 2; c++)
        if (tx_start[c] && loc_pend_q[c]) loc_pend_q[c] <= 1'b0;
      if (want_send) begin
        // both directions on a dual card, one direction otherwise
        loc_pend_q <= dual_q ? 2'b11 : 2'b01;
      end
      if (launch) begin
        sent_stat_q <= tx_stat_q;
        integ_cnt_q <= IW'(INTEGRITY_CYCLES - 1);
      end else if (integ_cnt_q != '0) begin
        integ_cnt_q <= integ_cnt_q - 1'b1;
      end
    end
  end

  // forwarding slots; a busy slot drops the newer frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_pend_q     <= '0;
      fwd_frame_q[0] <= '0;
      fwd_frame_q[1] <= '0;
    end else if (ce) begin
      for (int c = 0; c < 2; c++)
        if (tx_start[c] && !loc_pend_q[c]) fwd_pend_q[c] <= 1'b0;
      // own-number frames never reach a slot, so nothing loops
      if (en && rx_peer[0] && !fwd_pend_q[0]) begin
        fwd_pend_q[0]  <= 1'b1;
        fwd_frame_q[0] <= rx_frame[0];
      end
      if (en && dual_q && !fwd_pend_q[1]) begin
        if (rx_peer[1]) begin
          fwd_pend_q[1]  <= 1'b1;
          fwd_frame_q[1] <= rx_frame[1];
        end else if (rx_peer[0] && ctrl_q[CTRL_BRIDGE_BIT]) begin
          fwd_pend_q[1]  <= 1'b1;
          fwd_frame_q[1] <= rx_frame[0];
        end
      end
    end
  end

  // ring return check: a send with the last one still out is a break
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outstanding_q <= 1'b0;
      ring_break    <= 1'b0;
    end else if (ce) begin
      if (|rx_own) begin
        outstanding_q <= 1'b0;
        ring_break    <= 1'b0;
      end
      if (!ctrl_q[CTRL_RING_BIT]) ring_break <= 1'b0;
      if (break_ev) ring_break <= 1'b1;
      if (launch) outstanding_q <= 1'b1;
    end
  end

  // peer reception and offline window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_stat_q <= '0;
      rx_node_q <= '0;
      seen_q    <= '0;
      offline_q <= '0;
      win_cnt_q <= '0;
    end else if (ce) begin
      for (int c = 0; c < 2; c++)
        if (en && rx_peer[c]) begin
          rx_stat_q <= rx_frame[c][STAT_W-1:0];
          rx_node_q <= rx_frame[c][BODY_W-1:STAT_W];
        end
      if (!en) begin
        seen_q    <= '0;
        offline_q <= '0;
        win_cnt_q <= OW'(OFFLINE_CYCLES - 1);
      end else if (win_end) begin
        // a frame landing on the closing edge still counts
        offline_q <= ~(seen_q | seen_now);
        offline_q[local_node_number] <= 1'b0;
        seen_q    <= '0;
        win_cnt_q <= OW'(OFFLINE_CYCLES - 1);
      end else begin
        seen_q    <= seen_q | seen_now;
        offline_q <= offline_q & ~seen_now;
        win_cnt_q <= win_cnt_q - 1'b1;
      end
    end
  end

  // the two channels; channel two idles when not fitted
  link_channel #(.FW(FRAME_W)) u_ch1 (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .bit_cyc  (bit_cyc),
    .tx_start (tx_start[0]),
    .tx_frame (tx_frame[0]),
    .tx_busy  (tx_busy[0]),
    .tx_line  (tx_line_1),
    .rx_line  (rx_line_1),
    .rx_valid (rx_valid[0]),
    .rx_frame (rx_frame[0])
  );

  link_channel #(.FW(FRAME_W)) u_ch2 (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .bit_cyc  (bit_cyc),
    .tx_start (tx_start[1]),
    .tx_frame (tx_frame[1]),
    .tx_busy  (tx_busy[1]),
    .tx_line  (tx_line_2),
    .rx_line  (dual_q ? rx_line_2 : 1'b1),
    .rx_valid (rx_valid[1]),
    .rx_frame (rx_frame[1])
  );

endmodule

// ==== verif/ring_messenger_props.sv ====
/* port checker for the messenger: apb timing, error map, idle lines.
   assumes ce is held high and a single pclk domain. */
module ring_messenger_checker
  import ring_messenger_pkg::*;
(
  input wire logic              pclk,       // clock
  input wire logic              presetn,    // reset, active low
  input wire logic [ADDR_W-1:0] paddr,      // apb address
  input wire logic              psel,       // apb select
  input wire logic              penable,    // apb access phase
  input wire logic              pwrite,     // apb write
  input wire logic [31:0]       pwdata,     // apb write data
  input wire logic [31:0]       prdata,     // apb read data
  input wire logic              pready,     // apb ready
  input wire logic              pslverr,    // apb error
  input wire logic              tx_line_1,  // channel one serial out
  input wire logic              tx_line_2,  // channel two serial out
  input wire logic              ring_break, // ring return flag
  input wire logic              irq         // level interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
  a_ready_timing: assert property ((psel && !penable ##1 psel && penable)
    |=> pready) else $error("ready not on second access cycle");
  a_err_map: assert property (pready |-> pslverr ==
    (paddr[1:0] != 2'h0 || paddr > LINK_INFO_OFS)) else $error("bad error");
  a_err_rd_zero: assert property (pready && pslverr && !pwrite
    |-> prdata == 32'h0) else $error("refused read not zero");
  // irq is one cycle behind the mask register
  a_mask_quiet: assert property (pready && pwrite && paddr == IRQ_MASK_OFS
    && pwdata[3:0] == 4'h0 |-> ##2 !irq) else $error("masked irq high");
  a_upper_zero: assert property (pready && !pwrite && paddr == NODE_OFS
    |-> prdata[31:4] == 28'h0) else $error("node upper bits set");
  a_reset_idle: assert property ($rose(presetn) |-> tx_line_1 && !ring_break
    && !irq && tx_line_2) else $error("outputs not idle after reset");
  // a start bit is hundreds of cycles long at either rate
  a_start_hold: assert property ($fell(tx_line_1) |-> !tx_line_1 [*8])
    else $error("start bit too short");
  c_break: cover property ($rose(ring_break));
  c_irq: cover property (irq);
  c_refused: cover property (pready && pslverr);
endmodule
bind peer_status_ring_messenger ring_messenger_checker u_ring_messenger_checker (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
  .pready, .pslverr, .tx_line_1, .tx_line_2, .ring_break, .irq);

// ==== verif/peer_model.sv ====
/* far-side peer on both channels: relays every frame back a cycle later.
   assumes the device and the peer share one bit rate. */
module peer_model (
  input  wire logic pclk,            // clock
  input  wire logic pass,            // link healthy
  input  wire logic tx_in,           // device serial out, channel one
  input  wire logic tx_in_2,         // device serial out, channel two
  output logic      rx_out = 1'b1,   // device serial in, channel one
  output logic      rx_out_2 = 1'b1  // device serial in, channel two
);
  timeunit 1ns;
  timeprecision 1ps;
  // a cut link idles high, as a released line would
  // a pure relay never originates, so its number cannot clash
  always @(posedge pclk) begin
    rx_out   <= pass ? tx_in : 1'b1;
    rx_out_2 <= pass ? tx_in_2 : 1'b1;
  end
endmodule

// ==== verif/test_peer_status_ring_messenger.sv ====
/* bench for the messenger: apb master, relaying peer on both channels,
   random register traffic, a ring cut and the interrupt path. */
module test_peer_status_ring_messenger
  import ring_messenger_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              pclk = 1'b0, presetn = 1'b0, pass = 1'b1; // clk, reset
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // request
  logic [ADDR_W-1:0] paddr = 8'h00;                // apb address
  logic [31:0]       pwdata = 32'h0, prdata, v;    // apb data, random word
  logic              pready, pslverr, tx_line_1, tx_line_2, rx_line_1;
  logic              ring_break, irq, rx_line_2, ce = 1'b1; // flags, inputs
  int                miscompares = 0, n_tests = 0; // counts
  initial forever #12.5 pclk = ~pclk;              // 40 MHz
  peer_status_ring_messenger #(.INTEGRITY_CYCLES(2000), .OFFLINE_CYCLES(5000))
    u_peer_status_ring_messenger (.pclk, .presetn, .ce, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .dual_channel_card(1'b1), .fibre_card(1'b1), .fixed_rate_card(1'b0),
    .rx_line_1, .rx_line_2, .tx_line_1, .tx_line_2, .ring_break, .irq);
  peer_model u_peer_model (.pclk, .pass, .tx_in(tx_line_1),
    .tx_in_2(tx_line_2), .rx_out(rx_line_1), .rx_out_2(rx_line_2));
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  // one transfer; m picks the bits of {pslverr, prdata} to compare
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] m, input logic [32:0] x);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
    if (m != 33'h0) chk({pslverr, prdata} & m, x);
  endtask
  function automatic logic [32:0] info_exp(input logic fast);
    return {29'h0, fast, 3'b011}; // fixed strap low, fibre and dual high
  endfunction
  task automatic test_done;
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #2_400_000; // about 16k cycles past the planned run of about 80k, under 100k cycles
    miscompares++;
    test_done;
  end
  initial begin
    v = $urandom(74750);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0, 33'h1_FFFF_FFFF, 33'h0);
    apb(1'b0, NODE_OFS, 32'h0, 33'h1_FFFF_FFFF, 33'h1);
    apb(1'b1, 8'h20, v, 33'h1_0000_0000, 33'h1_0000_0000);
    apb(1'b0, 8'h22, 32'h0, 33'h1_FFFF_FFFF, 33'h1_0000_0000);
    $display("test reset_values done");
    repeat (4) begin
      v = $urandom;
      apb(1'b1, NODE_OFS, v, 33'h0, 33'h0);
      apb(1'b0, NODE_OFS, 32'h0, 33'h1_FFFF_FFFF, {29'h0, v[3:0]});
      apb(1'b1, LINK_INFO_OFS, v, 33'h0, 33'h0);
      apb(1'b0, LINK_INFO_OFS, 32'h0, 33'hF, info_exp(1'b0));
    end
    $display("test register_access done");
    apb(1'b1, IRQ_MASK_OFS, 32'h1, 33'h0, 33'h0);
    apb(1'b1, CTRL_OFS, 32'hB, 33'h0, 33'h0); // enable, ring, fast
    apb(1'b0, LINK_INFO_OFS, 32'h0, 33'hF, info_exp(1'b1));
    ce <= 1'b0; // freeze mid frame, the ring must survive it
    repeat (20) @(posedge pclk);
    ce <= 1'b1;
    repeat (40000) @(posedge pclk);
    chk(ring_break, 33'h0);
    pass <= 1'b0; // cut the ring
    repeat (40000) @(posedge pclk);
    chk({ring_break, irq}, 33'h3);
    apb(1'b0, IRQ_STAT_OFS, 32'h0, 33'h1, 33'h1);
    apb(1'b1, IRQ_MASK_OFS, 32'h0, 33'h0, 33'h0);
    repeat (3) @(posedge pclk);
    chk(irq, 33'h0);
    apb(1'b1, CTRL_OFS, 32'h9, 33'h0, 33'h0); // ring mode off
    apb(1'b1, IRQ_STAT_OFS, 32'h1, 33'h0, 33'h0);
    apb(1'b0, IRQ_STAT_OFS, 32'h0, 33'h1, 33'h0);
    chk(ring_break, 33'h0);
    $display("test ring_break done");
    test_done;
  end
endmodule
